// >>> design/pipelined_adc_output_port.sv
module pipelined_adc_output_port (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic convertClk,
  input wire logic [adc_port_pkg::SAMPLE_WIDTH-1:0] sampleIn,
  input wire logic outputFloat,
  input wire logic topBitInvert,
  input wire logic resultReady,
  output logic [adc_port_pkg::DATA_WIDTH-1:0] resultOut,
  output logic resultOe,
  output logic resultValid,
  output logic bufferReady,
  output logic wordDropped,
  output logic convertStalled
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] clkSync;
    logic [1:0] floatSync;
    logic [1:0] invertSync;
    logic [adc_port_pkg::PIPE_DEPTH-1:0][adc_port_pkg::DATA_WIDTH-1:0] pipe;
    logic oe;
    logic [adc_port_pkg::DATA_WIDTH-1:0] word;
    logic wordValid;
    logic [12:0] idleCount;
    logic stalled;
  } port_state_s;

  port_state_s s_q;
  port_state_s s_d;
  logic [1:0] rstPipe;
  logic rstN;
  logic fall;
  logic rise;
  logic signed [14:0] offsetSum;
  logic [adc_port_pkg::DATA_WIDTH-1:0] codeClamped;
  logic [adc_port_pkg::DATA_WIDTH-1:0] pushData;
  logic bufValid;
  logic [adc_port_pkg::DATA_WIDTH-1:0] bufData;
  logic take;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  // only the release is synchronised; assertion stays asynchronous so the bus goes quiet at once
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstN = rstPipe[1];

  // ----------------------------------------------------------------
  // quantizer stand-in and edge detect
  // ----------------------------------------------------------------
  // only the second and third sync flops are looked at
  assign fall = s_q.clkSync[2] && !s_q.clkSync[1];
  assign rise = !s_q.clkSync[2] && s_q.clkSync[1];

  // offset binary: input zero lands on mid-scale
  assign offsetSum = $signed({sampleIn[adc_port_pkg::SAMPLE_WIDTH-1], sampleIn}) + 15'sh0800;

  always_comb begin
    if (offsetSum < 15'sh0000) begin
      codeClamped = adc_port_pkg::MIN_CODE;
    end else if (offsetSum > 15'sh0FFF) begin
      codeClamped = adc_port_pkg::MAX_CODE;
    end else begin
      codeClamped = offsetSum[11:0];
    end
  end

  // coding is picked as the word leaves the pipe so the bus never sees a half-changed word
  assign pushData = {s_q.pipe[adc_port_pkg::PIPE_DEPTH-1][adc_port_pkg::RESULT_BIT_MSB] ^ s_q.invertSync[1],
                     s_q.pipe[adc_port_pkg::PIPE_DEPTH-1][adc_port_pkg::RESULT_BIT_MSB-1:0]};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.clkSync = {s_q.clkSync[1:0], convertClk};
    s_d.floatSync = {s_q.floatSync[0], outputFloat};
    s_d.invertSync = {s_q.invertSync[0], topBitInvert};
    if (fall) begin
      s_d.pipe = {s_q.pipe[adc_port_pkg::PIPE_DEPTH-2:0], codeClamped};
    end
    s_d.oe = !s_q.floatSync[1];
    if (take) begin
      s_d.word = bufData;
      s_d.wordValid = 1'b1;
    end else if (resultReady) begin
      s_d.wordValid = 1'b0;
    end
    // stall watch: no fall within the slowest legal period
    // the flag only warns; words already in the pipe still drain on later rises
    if (fall) begin
      s_d.idleCount = 13'h0000;
      s_d.stalled = 1'b0;
    end else if (s_q.idleCount >= adc_port_pkg::STALL_LIMIT) begin
      s_d.stalled = 1'b1;
    end else begin
      s_d.idleCount = 13'(s_q.idleCount + 1'b1);
    end
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // output buffer
  // ----------------------------------------------------------------
  // the convert clock cannot be held back, so a full buffer drops the word and says so
  word_buffer #(
    .WIDTH(adc_port_pkg::DATA_WIDTH),
    .DEPTH(adc_port_pkg::BUFFER_DEPTH)
  ) u_buffer (
    .clk(ref_clk),
    .rstN(rstN),
    .inValid(rise),
    .inReady(bufferReady),
    .inData(pushData),
    .outValid(bufValid),
    .outReady(take),
    .outData(bufData)
  );

  assign take = bufValid && (!s_q.wordValid || resultReady);
  assign wordDropped = rise && !bufferReady;
  assign resultOut = s_q.word;
  assign resultOe = s_q.oe;
  assign resultValid = s_q.wordValid;
  assign convertStalled = s_q.stalled;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstN);

  a_fall_capture: assert property (fall |=> s_q.pipe[0] == $past(codeClamped))
    else $error("fall did not capture the sample");
  a_pipe_hold: assert property (!fall |=> $stable(s_q.pipe))
    else $error("pipe moved without a fall");
  a_pipe_advance: assert property (fall |=> s_q.pipe[6] == $past(s_q.pipe[5]))
    else $error("pipe did not advance on fall");
  a_bus_order: assert property (rise |-> pushData[10:0] == s_q.pipe[6][10:0])
    else $error("result lines out of order");
  a_float_hiz: assert property (s_q.floatSync[1] |=> !resultOe)
    else $error("outputs driven while floated");
  a_top_invert: assert property (rise |-> (pushData[11] != s_q.pipe[6][11]) == s_q.invertSync[1])
    else $error("top bit coding wrong");
  a_clamp_high: assert property ($signed(sampleIn) > 14'sh07FF |-> codeClamped == 12'hFFF)
    else $error("overrange did not clamp high");
  a_clamp_low: assert property ($signed(sampleIn) < -14'sh0800 |-> codeClamped == 12'h000)
    else $error("underrange did not clamp low");
  a_mid_scale: assert property (sampleIn == 14'h0000 |-> codeClamped == 12'h800)
    else $error("mid-scale code wrong");
  a_full_scale: assert property ($signed(sampleIn) == 14'sh07FF |-> codeClamped == adc_port_pkg::MAX_CODE)
    else $error("full-scale code wrong");
  a_zero_scale: assert property ($signed(sampleIn) == -14'sh0800 |-> codeClamped == adc_port_pkg::MIN_CODE)
    else $error("negative full-scale code wrong");
  a_float_drive: assert property (!s_q.floatSync[1] |=> resultOe)
    else $error("outputs not driven while float low");

  for (genvar g = 1; g < adc_port_pkg::PIPE_DEPTH; g++) begin : g_stage
    a_stage_shift: assert property (fall |=> s_q.pipe[g] == $past(s_q.pipe[g-1]))
      else $error("pipe stage did not shift on fall");
  end

  // a word offered to capture must not change under it
  a_word_hold: assert property (resultValid && !resultReady |=> resultValid && $stable(resultOut))
    else $error("offered word changed before it was taken");
  a_buffer_take: assert property (take |=> resultValid && resultOut == $past(bufData))
    else $error("buffered word not presented");
  a_valid_drop: assert property (resultValid && resultReady && !bufValid |=> !resultValid)
    else $error("valid stayed up after last word was taken");
  a_room_push: assert property (rise && bufferReady |=> bufValid)
    else $error("word with room was not buffered");

  a_stall_set: assert property (s_q.idleCount >= adc_port_pkg::STALL_LIMIT && !fall |=> convertStalled)
    else $error("stall not flagged");
  a_stall_hold: assert property (convertStalled && !fall |=> convertStalled)
    else $error("stall flag dropped without a fall");
  a_stall_clear: assert property (fall |=> !convertStalled && s_q.idleCount == 13'h0000)
    else $error("fall did not clear the stall watch");

  c_conversion: cover property (fall ##[1:20] rise);
  c_inverted_word: cover property (rise && s_q.invertSync[1]);
  c_buffer_full: cover property (rise && !bufferReady);

  // ----------------------------------------------------------------
  // control scenarios
  // ----------------------------------------------------------------
  c_float_release: cover property ($fell(resultOe));
  c_stall: cover property ($rose(convertStalled));

endmodule

// >>> shared/adc_port_pkg.sv
package adc_port_pkg;

  // ----------------------------------------------------------------
  // data word
  // ----------------------------------------------------------------
  localparam int DATA_WIDTH = 12;
  localparam int RESULT_BIT_MSB = 11;
  localparam int RESULT_BIT_LSB = 0;
  localparam int SAMPLE_WIDTH = 14;
  localparam logic [11:0] MIN_CODE = 12'h000;
  localparam logic [11:0] MID_CODE = 12'h800;
  localparam logic [11:0] MAX_CODE = 12'hFFF;

  // ----------------------------------------------------------------
  // pipeline timing
  // ----------------------------------------------------------------
  localparam int LATENCY_HALF_CYCLES = 13;
  localparam int PIPE_DEPTH = LATENCY_HALF_CYCLES / 2 + 1;
  localparam int BUFFER_DEPTH = 2;

  // ----------------------------------------------------------------
  // clock rates
  // ----------------------------------------------------------------
  localparam longint REF_CLK_HZ = 40000000;
  localparam longint MIN_SAMPLE_RATE_HZ = 10000;
  localparam longint MAX_SAMPLE_RATE_HZ = 25000000;
  localparam int STALL_CYCLES = int'(REF_CLK_HZ / MIN_SAMPLE_RATE_HZ);
  localparam logic [12:0] STALL_LIMIT = 13'(STALL_CYCLES);

endpackage

// >>> design/word_buffer.sv
module word_buffer #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [CW-1:0] count;
  } buf_state_s;

  buf_state_s s_q;
  buf_state_s s_d;
  logic push;
  logic pop;

  assign inReady = (s_q.count != CW'(DEPTH));
  assign outValid = (s_q.count != '0);
  assign outData = s_q.mem[s_q.rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wrPtr] = inData;
      s_d.wrPtr = (s_q.wrPtr == PW'(DEPTH - 1)) ? '0 : PW'(s_q.wrPtr + 1'b1);
    end
    if (pop) begin
      s_d.rdPtr = (s_q.rdPtr == PW'(DEPTH - 1)) ? '0 : PW'(s_q.rdPtr + 1'b1);
    end
    if (push && !pop) begin
      s_d.count = CW'(s_q.count + 1'b1);
    end else if (pop && !push) begin
      s_d.count = CW'(s_q.count - 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// >>> test/capture_partner.sv
module capture_partner (
  input wire logic ref_clk,
  input wire logic run,
  input wire logic [3:0] halfLen,
  input wire logic stallEn,
  input wire logic [11:0] busLine,
  input wire logic resultValid,
  input wire logic resultOe,
  output logic convertClk,
  output logic resultReady,
  output logic gotWord,
  output logic [11:0] gotData
);
  timeunit 1ns;
  timeprecision 100ps;
  int ph = 0;
  int seen = 0;
  initial begin
    convertClk = 1'b0;
    resultReady = 1'b0;
    gotWord = 1'b0;
    gotData = 12'h000;
  end
  // equal halves; clock stands low while not running
  always @(negedge ref_clk) begin
    resultReady <= stallEn ? 1'b0 : ($urandom % 4 != 0);
    if (!run) begin
      convertClk <= 1'b0;
      ph <= 0;
    end else if (ph == halfLen - 1) begin
      convertClk <= ~convertClk;
      ph <= 0;
    end else begin
      ph <= ph + 1;
    end
  end
  always @(posedge ref_clk) begin
    gotWord <= 1'b0;
    if (!run) begin
      seen <= 0;
    end else if (resultValid && resultReady && resultOe) begin
      seen <= seen + 1;
      if (seen >= 7) begin
        gotWord <= 1'b1;
        gotData <= busLine;
      end
    end
  end
endmodule

// >>> test/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 0, resetn = 0, outputFloat = 0, topBitInvert = 0, run = 0, stallEn = 0, prevClk = 0;
  logic convertClk, resultReady, gotWord, resultOe, resultValid, bufferReady, wordDropped, convertStalled;
  logic [13:0] sampleIn = 14'h0000;
  logic [11:0] resultOut, gotData, busLine;
  logic [3:0] halfLen = 4'h4;
  logic [11:0] expQ[$];
  int err_total = 0, checked = 0, cycles = 0;
  always #12.5 ref_clk = ~ref_clk;
  // released bus shows the held word inverted, never the word itself
  assign busLine = resultOe ? resultOut : ~resultOut;
  pipelined_adc_output_port uut (.ref_clk(ref_clk), .resetn(resetn), .convertClk(convertClk),
    .sampleIn(sampleIn), .outputFloat(outputFloat), .topBitInvert(topBitInvert), .resultReady(resultReady),
    .resultOut(resultOut), .resultOe(resultOe), .resultValid(resultValid), .bufferReady(bufferReady),
    .wordDropped(wordDropped), .convertStalled(convertStalled));
  capture_partner cap (.ref_clk(ref_clk), .run(run), .halfLen(halfLen), .stallEn(stallEn), .busLine(busLine),
    .resultValid(resultValid), .resultOe(resultOe), .convertClk(convertClk), .resultReady(resultReady),
    .gotWord(gotWord), .gotData(gotData));
  function automatic logic [11:0] model(int s, bit inv);
    int c;
    c = s > 2047 ? 2047 : (s < -2048 ? -2048 : s);
    c = c + 2048;
    if (inv) c = c ^ 2048;
    return 12'(c);
  endfunction
  function automatic logic [13:0] pick();
    int v;
    case ($urandom % 8)
      0: v = 2047;
      1: v = -2048;
      2: v = 0;
      3: v = 3000;
      4: v = -3000;
      default: v = int'($urandom % 4096) - 2048;
    endcase
    return 14'(v);
  endfunction
  task cmpWord(string n, logic [11:0] e, logic [11:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task cmpBit(string n, logic e, logic g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask
  task results;
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(negedge ref_clk) begin
    cycles <= cycles + 1;
    prevClk <= convertClk;
    if (run && convertClk && !prevClk) sampleIn <= pick();
    if (run && !convertClk && prevClk) expQ.push_back(model($signed(sampleIn), topBitInvert));
    if (gotWord && expQ.size() > 0) cmpWord("result", expQ.pop_front(), gotData);
    else if (gotWord) cmpWord("result unexpected", ~gotData, gotData);
    if (cycles == 60000) begin
      err_total++;
      results();
    end
  end
  initial begin
    void'($urandom(32'h2372));
    for (int inv = 0; inv < 2; inv++) begin
      @(negedge ref_clk);
      resetn = 0;
      run = 0;
      topBitInvert = inv[0];
      expQ.delete();
      repeat (5) @(negedge ref_clk);
      resetn = 1;
      repeat (6) @(negedge ref_clk);
      cmpBit("oe", 1'b1, resultOe);
      halfLen = inv ? 4'h2 : 4'h4;
      run = 1;
      repeat (700) @(negedge ref_clk);
      cmpBit("stalled", 1'b0, convertStalled);
      run = 0;
      repeat (10) @(negedge ref_clk);
      outputFloat = 1;
      repeat (5) @(negedge ref_clk);
      cmpBit("oe float", 1'b0, resultOe);
      outputFloat = 0;
      repeat (5) @(negedge ref_clk);
      cmpBit("oe drive", 1'b1, resultOe);
    end
    stallEn = 1;
    run = 1;
    for (int i = 0; i < 300 && wordDropped !== 1'b1; i++) @(negedge ref_clk);
    cmpBit("dropped", 1'b1, wordDropped);
    cmpBit("buffer ready", 1'b0, bufferReady);
    cmpBit("valid", 1'b1, resultValid);
    run = 0;
    repeat (4100) @(negedge ref_clk);
    cmpBit("stalled", 1'b1, convertStalled);
    results();
  end
endmodule
